// ==== hw/aisc_mem_if.sv ====
`timescale 1ns/1ps
interface aisc_mem_if;
  import aisc_pkg::*;
  logic              we;
  logic [MEM_AW-1:0] waddr;
  logic [DW-1:0]     wdata;
  logic              re;
  logic [MEM_AW-1:0] raddr;
  logic [DW-1:0]     rdata;

  modport ctrl (output we, output waddr, output wdata,
                output re, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata,
                input re, input raddr, output rdata);
endinterface : aisc_mem_if

// ==== hw/aisc_pkg.sv ====
package aisc_pkg;

  // ---------------------------------------------------------------------------
  // Sizes and register windows
  // ---------------------------------------------------------------------------
  localparam int          CH_N       = 2;
  localparam int          DW         = 16;
  localparam int          AW         = 8;
  localparam int          IDX_W      = 6;
  localparam int          MEM_AW     = 7;
  localparam int          WORDS      = 64;
  localparam logic [5:0]  TYPE_LO    = 6'h08;
  localparam logic [5:0]  TYPE_HI    = 6'h0F;
  localparam logic [5:0]  FAC_LO     = 6'h10;
  localparam logic [5:0]  USR_LO     = 6'h1F;
  localparam logic [5:0]  EXT_LO     = 6'h30;

  // Word indices inside one channel's 64-word structure
  localparam logic [5:0]  IDX_RAW      = 6'h00;
  localparam logic [5:0]  IDX_PDATA    = 6'h01;
  localparam logic [5:0]  IDX_TYPE     = 6'h08;
  localparam logic [5:0]  IDX_CHANS    = 6'h0B;
  localparam logic [5:0]  IDX_CAL_OFF  = 6'h11;
  localparam logic [5:0]  IDX_CAL_GAIN = 6'h12;
  localparam logic [5:0]  IDX_FAC_OFF  = 6'h13;
  localparam logic [5:0]  IDX_FAC_GAIN = 6'h14;
  localparam logic [5:0]  IDX_FEAT     = 6'h20;
  localparam logic [5:0]  IDX_USR_OFF  = 6'h21;
  localparam logic [5:0]  IDX_USR_GAIN = 6'h22;

  // Block-level registers (address bit 7 set)
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h80;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h81;

  // Feature configuration word fields
  localparam int          FEAT_FAC_BIT  = 0;
  localparam int          FEAT_USR_BIT  = 1;
  localparam int          FEAT_FMT_LO   = 2;
  localparam int          FEAT_FAST_BIT = 4;

  typedef enum logic [1:0] {
    FMT_TWOS    = 2'b00,
    FMT_SIGNMAG = 2'b01,
    FMT_OFFBIN  = 2'b10,
    FMT_RSVD    = 2'b11
  } aisc_fmt_t;

  // Reset values; gains are signed with 1.0 at 0x4000
  localparam int          GAIN_FRAC     = 14;
  localparam logic [15:0] RST_GAIN      = 16'h4000;
  localparam logic [15:0] RST_OFF       = 16'h0000;
  localparam logic [15:0] RST_FEAT      = 16'h0001;
  localparam logic [15:0] TYPE_CODE     = 16'h0C1E; // Arbitrary value
  localparam logic [15:0] CHAN_CNT      = 16'h0002;
  localparam logic [15:0] POS_FULL      = 16'h7FFF;
  localparam logic [15:0] NEG_FULL      = 16'h8000;

  // Interrupt status layout
  localparam int          IRQ_W         = 6;
  localparam int          IRQ_RDY_LO    = 0;
  localparam int          IRQ_WDOG_LO   = 2;
  localparam int          IRQ_SAT_LO    = 4;

  // Process image sizes in bytes
  localparam logic [3:0]  IMG_BYTES_DATA = 4'h4;
  localparam logic [3:0]  IMG_BYTES_CS   = 4'h6;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ          = 20_000_000;
  localparam int T_CONV_SLOW_MS  = 140;
  localparam int T_CONV_FAST_MS  = 2;
  localparam int T_WDOG_MS       = 100;
  localparam int CYC_CONV_SLOW   = T_CONV_SLOW_MS * (CLK_HZ / 1000);
  localparam int CYC_CONV_FAST   = T_CONV_FAST_MS * (CLK_HZ / 1000);
  localparam int CYC_WDOG        = T_WDOG_MS * (CLK_HZ / 1000);
  localparam int CONV_W          = 22;
  localparam int WDOG_W          = 21;

endpackage : aisc_pkg

// ==== hw/aisc_regmem.sv ====
`timescale 1ns/1ps
// Plain word store for both channels' register structures
module aisc_regmem
  import aisc_pkg::*;
(
  input wire logic ref_clk,
  aisc_mem_if.mem  port
);
  logic [DW-1:0] words [0:CH_N*WORDS-1];

  // Write then registered read; no reset, contents are working RAM
  always_ff @(posedge ref_clk) begin
    if (port.we) begin
      words[port.waddr] <= port.wdata;
    end
    if (port.re) begin
      port.rdata <= words[port.raddr];
    end
  end
endmodule : aisc_regmem

// ==== hw/aisc_top.sv ====
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// What this block does
// - Default output is two's complement word
// - Feature word selects sign-magnitude or alternate format
// - No scaling: output calibrated (offset+raw)*gain
// - Factory only (default): factory offset plus gain*value
// - User only: user offset plus gain*value
// - Both: factory first, then user scaling
// - Scaling enables come from feature word bits
// - Run indicator off after 100 ms without transfer
// - Sample every 140 ms, filter allows 2 ms
// - Each channel has 64 word registers
// - Areas: process, type, factory, user, extended
// - Every channel owns its own register set
// - Without control byte, image is 4 bytes
// - Process variables live in volatile RAM
module aisc_top
  import aisc_pkg::*;
#(
  parameter int CONV_SLOW_CYCLES = CYC_CONV_SLOW,
  parameter int CONV_FAST_CYCLES = CYC_CONV_FAST,
  parameter int WDOG_CYCLES      = CYC_WDOG
) (
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire logic [AW-1:0]         reg_addr,
  input  wire logic [DW-1:0]         reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [DW-1:0]         reg_rdata,
  input  wire logic [CH_N-1:0][DW-1:0] adc_sample,
  input  wire logic                  proc_xfer,
  input  wire logic                  cs_byte_en,
  output logic      [CH_N-1:0][DW-1:0] proc_data,
  output logic      [CH_N-1:0]       run_led,
  output logic      [3:0]            image_bytes,
  output logic                       irq
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [CH_N-1:0][DW-1:0]     cal_off;
    logic [CH_N-1:0][DW-1:0]     cal_gain;
    logic [CH_N-1:0][DW-1:0]     fac_off;
    logic [CH_N-1:0][DW-1:0]     fac_gain;
    logic [CH_N-1:0][DW-1:0]     feat;
    logic [CH_N-1:0][DW-1:0]     usr_off;
    logic [CH_N-1:0][DW-1:0]     usr_gain;
    logic [CH_N-1:0][DW-1:0]     raw;
    logic [CH_N-1:0][DW-1:0]     pdata;
    logic [CH_N-1:0]             upd;
    logic [CH_N-1:0][CONV_W-1:0] conv;
    logic [CH_N-1:0][WDOG_W-1:0] wdog;
    logic [CH_N-1:0]             run;
    logic [IRQ_W-1:0]            irq_stat;
    logic [IRQ_W-1:0]            irq_mask;
    logic                        ovl;
    logic [DW-1:0]               ovl_data;
    logic [3:0]                  img;
  } aisc_state_t;

  aisc_state_t s;
  aisc_state_t next_s;

  aisc_mem_if mem_bus ();

  // ---------------------------------------------------------------------------
  // Arithmetic helper
  // ---------------------------------------------------------------------------
  // ((pre + x) * gain >> frac) + post, clipped; bit 16 flags a clip
  function automatic logic [16:0] scale(input logic [15:0] pre,
                                        input logic [15:0] x,
                                        input logic [15:0] gain,
                                        input logic [15:0] post);
    logic signed [16:0] sum;
    logic signed [34:0] prod;
    logic signed [34:0] res;
    sum  = $signed({pre[15], pre}) + $signed({x[15], x});
    // Widen both factors first so the product is never cut short
    prod = 35'(sum) * 35'($signed(gain));
    res  = (prod >>> GAIN_FRAC) + 35'($signed(post));
    if (res > 35'sd32767) begin
      scale = {1'b1, POS_FULL};
    end else if (res < -35'sd32768) begin
      scale = {1'b1, NEG_FULL};
    end else begin
      scale = {1'b0, res[15:0]};
    end
  endfunction : scale

  // ---------------------------------------------------------------------------
  // Per-channel scaling and formatting
  // ---------------------------------------------------------------------------
  logic [CH_N-1:0][DW-1:0] fmt_word;
  logic [CH_N-1:0]         sat_hit;

  for (genvar g = 0; g < CH_N; g++) begin : g_ch
    logic [16:0]   ya;
    logic [16:0]   y1;
    logic [16:0]   y2;
    logic [16:0]   yout;
    logic [DW-1:0] mag;
    logic          fac_en;
    logic          usr_en;
    aisc_fmt_t     fmt;

    // Enables and format straight from the feature word
    assign fac_en = s.feat[g][FEAT_FAC_BIT];
    assign usr_en = s.feat[g][FEAT_USR_BIT];
    assign fmt    = aisc_fmt_t'(s.feat[g][FEAT_FMT_LO +: 2]);

    // Calibration, then the two optional straight-line stages
    assign ya = scale(s.cal_off[g], s.raw[g], s.cal_gain[g],
                      RST_OFF);
    assign y1 = fac_en ? scale(RST_OFF, ya[15:0], s.fac_gain[g],
                               s.fac_off[g]) : ya;
    // User stage eats the factory result when both run
    assign y2 = scale(RST_OFF, y1[15:0], s.usr_gain[g],
                      s.usr_off[g]);
    assign yout = usr_en ? y2 : y1;

    assign sat_hit[g] = ya[16] | (fac_en & y1[16]) | (usr_en & y2[16]);

    // Negative full scale has no positive twin; clip magnitude
    assign mag = (yout[15:0] == NEG_FULL) ? POS_FULL
               : (yout[15] ? 16'(-yout[15:0]) : yout[15:0]);

    always_comb begin
      unique case (fmt)
        FMT_SIGNMAG: fmt_word[g] = {yout[15], mag[14:0]};
        FMT_OFFBIN:  fmt_word[g] = yout[15:0] ^ NEG_FULL;
        default:     fmt_word[g] = yout[15:0];
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------------------
  logic             blk_sel;
  logic             ch;
  logic [IDX_W-1:0] idx;
  logic             ro_area;

  assign blk_sel = reg_addr[AW-1];
  assign ch      = reg_addr[IDX_W];
  assign idx     = reg_addr[IDX_W-1:0];
  // Type words are ROM, extended area unimplemented, process words live
  assign ro_area = (idx >= TYPE_LO && idx <= TYPE_HI) || idx >= EXT_LO
                 || idx == IDX_RAW || idx == IDX_PDATA;

  // Generic words go to the shared store, one 64-word page per channel
  assign mem_bus.we    = reg_wr && !blk_sel && !ro_area;
  assign mem_bus.waddr = reg_addr[MEM_AW-1:0];
  assign mem_bus.wdata = reg_wdata;
  assign mem_bus.re    = reg_rd && !blk_sel;
  assign mem_bus.raddr = reg_addr[MEM_AW-1:0];

  aisc_regmem u_mem (
    .ref_clk (ref_clk),
    .port    (mem_bus.mem)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [CH_N-1:0] tick;
    logic [CH_N-1:0] wd_ovf;
    logic            stat_clr;
    logic            fast;
    tick     = '0;
    wd_ovf   = '0;
    stat_clr = 1'b0;
    fast     = 1'b0;
    next_s   = s;

    // Conversion timer per channel; >= lets a period change apply at once
    for (int c = 0; c < CH_N; c++) begin
      fast = s.feat[c][FEAT_FAST_BIT];
      if (( fast && s.conv[c] >= CONV_W'(CONV_FAST_CYCLES - 1)) ||
          (!fast && s.conv[c] >= CONV_W'(CONV_SLOW_CYCLES - 1))) begin
        tick[c]        = 1'b1;
        next_s.conv[c] = '0;
        next_s.raw[c]  = adc_sample[c];
      end else begin
        next_s.conv[c] = s.conv[c] + 1'b1;
      end
      // Raw value settles first, process word one cycle after
      next_s.upd[c] = tick[c];
      if (s.upd[c]) begin
        next_s.pdata[c] = fmt_word[c];
      end

      // Watchdog: any coupler transfer restarts it and relights RUN
      if (proc_xfer) begin
        next_s.wdog[c] = '0;
        next_s.run[c]  = 1'b1;
      end else if (s.wdog[c] == WDOG_W'(WDOG_CYCLES - 1)) begin
        wd_ovf[c]      = s.run[c];
        next_s.run[c]  = 1'b0;
      end else begin
        next_s.wdog[c] = s.wdog[c] + 1'b1;
      end
    end

    // Writes to shadowed parameter words steer the datapath
    if (reg_wr && !blk_sel) begin
      unique case (idx)
        IDX_CAL_OFF:  next_s.cal_off[ch]  = reg_wdata;
        IDX_CAL_GAIN: next_s.cal_gain[ch] = reg_wdata;
        IDX_FAC_OFF:  next_s.fac_off[ch]  = reg_wdata;
        IDX_FAC_GAIN: next_s.fac_gain[ch] = reg_wdata;
        IDX_FEAT:     next_s.feat[ch]     = reg_wdata;
        IDX_USR_OFF:  next_s.usr_off[ch]  = reg_wdata;
        IDX_USR_GAIN: next_s.usr_gain[ch] = reg_wdata;
        default:      ;
      endcase
    end
    if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
      next_s.irq_mask = reg_wdata[IRQ_W-1:0];
    end

    // Read overlay: live and ROM words bypass the store
    next_s.ovl      = 1'b0;
    next_s.ovl_data = '0;
    if (reg_rd) begin
      if (blk_sel) begin
        next_s.ovl = 1'b1;
        if (reg_addr == ADDR_IRQ_STAT) begin
          next_s.ovl_data = DW'(s.irq_stat);
          stat_clr        = 1'b1;
        end else if (reg_addr == ADDR_IRQ_MASK) begin
          next_s.ovl_data = DW'(s.irq_mask);
        end
      end else begin
        next_s.ovl = 1'b1;
        unique case (idx)
          IDX_RAW:      next_s.ovl_data = s.raw[ch];
          IDX_PDATA:    next_s.ovl_data = s.pdata[ch];
          IDX_TYPE:     next_s.ovl_data = TYPE_CODE;
          IDX_CHANS:    next_s.ovl_data = CHAN_CNT;
          IDX_CAL_OFF:  next_s.ovl_data = s.cal_off[ch];
          IDX_CAL_GAIN: next_s.ovl_data = s.cal_gain[ch];
          IDX_FAC_OFF:  next_s.ovl_data = s.fac_off[ch];
          IDX_FAC_GAIN: next_s.ovl_data = s.fac_gain[ch];
          IDX_FEAT:     next_s.ovl_data = s.feat[ch];
          IDX_USR_OFF:  next_s.ovl_data = s.usr_off[ch];
          IDX_USR_GAIN: next_s.ovl_data = s.usr_gain[ch];
          default:      next_s.ovl = ro_area;
        endcase
      end
    end

    // Sticky events; a new event beats the read-clear
    next_s.irq_stat = (stat_clr ? '0 : s.irq_stat)
                    | {sat_hit & s.upd, wd_ovf, tick};

    // Image length follows whether the control byte is carried
    next_s.img = cs_byte_en ? IMG_BYTES_CS : IMG_BYTES_DATA;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s          <= '0;
      s.cal_gain <= {CH_N{RST_GAIN}};
      s.fac_gain <= {CH_N{RST_GAIN}};
      s.usr_gain <= {CH_N{RST_GAIN}};
      s.feat     <= {CH_N{RST_FEAT}};
      s.run      <= '1;
      s.img      <= IMG_BYTES_DATA;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign reg_rdata   = s.ovl ? s.ovl_data : mem_bus.rdata;
  assign proc_data   = s.pdata;
  assign run_led     = s.run;
  assign image_bytes = s.img;
  assign irq         = |(s.irq_stat & s.irq_mask);

endmodule : aisc_top

// ==== tb/aisc_coupler_model.sv ====
`timescale 1ns/1ps
// Coupler side: polls the process image and may stall on request
module aisc_coupler_model #(
  parameter int GAP = 8
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic hold,
  input  wire logic parm,
  output logic      proc_xfer,
  output logic      cs_byte_en
);
  // ---------------------------------------------------------------
  // Cyclic image transfer
  // ---------------------------------------------------------------
  logic [7:0] cnt;

  // One transfer pulse per GAP clocks; hold starves the watchdog
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt       <= 8'h00;
      proc_xfer <= 1'b0;
    end else begin
      cnt       <= (cnt == 8'(GAP - 1)) ? 8'h00 : cnt + 8'h01;
      proc_xfer <= !hold && (cnt == 8'h00);
    end
  end

  // Control byte mapped only while parametrizing
  assign cs_byte_en = parm;
endmodule : aisc_coupler_model

// ==== tb/aisc_properties.sv ====
`timescale 1ns/1ps
module aisc_properties
  import aisc_pkg::*;
#(
  parameter int WDOG_CYCLES = CYC_WDOG
) (
  input wire logic            ref_clk,
  input wire logic            arst_n,
  input wire logic [AW-1:0]   reg_addr,
  input wire logic [DW-1:0]   reg_wdata,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire logic [DW-1:0]   reg_rdata,
  input wire logic            proc_xfer,
  input wire logic            cs_byte_en,
  input wire logic [CH_N-1:0] run_led,
  input wire logic [3:0]      image_bytes,
  input wire logic            irq
);
  // ---------------------------------------------------------------
  // Helpers and properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [31:0] idle_n;

  // Idle count since last transfer; margins absorb counter phase
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) idle_n <= 32'h0000_0000;
    else if (proc_xfer) idle_n <= 32'h0000_0000;
    else if (idle_n != 32'hFFFF_FFFF) idle_n <= idle_n + 32'h0000_0001;
  end

  // Read of one word in a channel page
  sequence s_rd(logic [5:0] idx);
    reg_rd && !reg_addr[7] && reg_addr[5:0] == idx;
  endsequence
  // Feature write followed at once by a read of the same word
  sequence s_wr_rd;
    reg_wr && !reg_addr[7] && reg_addr[5:0] == IDX_FEAT
    ##1 reg_rd && reg_addr == $past(reg_addr);
  endsequence

  a_led_lit:
    assert property (idle_n < WDOG_CYCLES - 2 |-> run_led == 2'b11)
    else $error("run indicator dark during traffic");
  a_led_out:
    assert property (idle_n > WDOG_CYCLES + 1 |-> run_led == 2'b00)
    else $error("run indicator lit after silence");
  a_xfer_relight:
    assert property (proc_xfer |=> run_led == 2'b11)
    else $error("transfer did not relight indicator");
  a_img_cs:
    assert property (cs_byte_en |=> image_bytes == IMG_BYTES_CS)
    else $error("image size wrong with control byte");
  a_img_data:
    assert property (!cs_byte_en |=> image_bytes == IMG_BYTES_DATA)
    else $error("image size wrong without control byte");
  a_type_word:
    assert property (s_rd(IDX_TYPE) |=> reg_rdata == TYPE_CODE)
    else $error("type word read wrong");
  a_chan_count:
    assert property (s_rd(IDX_CHANS) |=> reg_rdata == CHAN_CNT)
    else $error("channel count read wrong");
  a_ext_zero:
    assert property (reg_rd && !reg_addr[7] && reg_addr[5:4] == 2'b11
                     |=> reg_rdata == 16'h0000)
    else $error("extended area not zero");
  a_blk_zero:
    assert property (reg_rd && reg_addr > 8'h81 |=> reg_rdata == 16'h0000)
    else $error("unmapped block read not zero");
  a_feat_back:
    assert property (s_wr_rd |=> reg_rdata == $past(reg_wdata, 2))
    else $error("feature word not read back");
  a_mask_off:
    assert property (reg_wr && reg_addr == ADDR_IRQ_MASK
                     && reg_wdata == 16'h0000 |=> !irq)
    else $error("irq high with mask cleared");
endmodule : aisc_properties

bind aisc_top aisc_properties #(.WDOG_CYCLES(WDOG_CYCLES)) u_props (
  .ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .proc_xfer, .cs_byte_en, .run_led, .image_bytes, .irq
);

// ==== tb/analog_input_scaling_channel_tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module analog_input_scaling_channel_tb import aisc_pkg::*;;
  // ---------------------------------------------------------------
  // Signals, design and coupler
  // ---------------------------------------------------------------
  typedef struct packed {logic [15:0] v; logic [15:0] m;} aisc_note_t;
  logic                      ref_clk = 0, arst_n = 0, reg_wr = 0;
  logic                      reg_rd = 0, hold = 0, parm = 0, rd_q = 0;
  logic [AW-1:0]             reg_addr = '0;
  logic [DW-1:0]             reg_wdata = '0, reg_rdata;
  logic [CH_N-1:0][DW-1:0]   adc_sample = {16'h8000, 16'h0000}, proc_data;
  logic                      proc_xfer, cs_byte_en, irq;
  logic [CH_N-1:0]           run_led;
  logic [3:0]                image_bytes;
  int                        num_errors = 0, n_tests = 0, seed = 32'h97E6;
  aisc_note_t                notes[$];

  always #25 ref_clk = ~ref_clk;

  aisc_top #(.CONV_SLOW_CYCLES(200), .CONV_FAST_CYCLES(20),
             .WDOG_CYCLES(100)) u_dut (.ref_clk, .arst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .adc_sample, .proc_xfer,
    .cs_byte_en, .proc_data, .run_led, .image_bytes, .irq);
  aisc_coupler_model u_cpl (.ref_clk, .arst_n, .hold, .parm,
    .proc_xfer, .cs_byte_en);

  // Read data stand one cycle after the strobe; oldest note first
  always @(posedge ref_clk) begin
    rd_q <= reg_rd;
    if (rd_q && notes.size() > 0) begin
      `CHK(reg_rdata & notes[0].m, notes[0].v)
      void'(notes.pop_front());
    end
  end

  // ---------------------------------------------------------------
  // Bus tasks, reference model, verdict
  // ---------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr <= 1'b1; reg_rd <= 1'b0; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] v);
    reg_rd <= 1'b1; reg_wr <= 1'b0; reg_addr <= a;
    notes.push_back({v, 16'hFFFF});
    @(posedge ref_clk);
  endtask : rd
  task idle(input int n);
    reg_wr <= 1'b0; reg_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask : idle
  task conclude;
    if (num_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  function automatic logic [15:0] sat(longint x);
    return (x > 32767) ? 16'h7FFF : (x < -32768) ? 16'h8000 : x[15:0];
  endfunction : sat
  // p: cal off, cal gain, fac off, fac gain, usr off, usr gain, feature
  function automatic logic [15:0] model(logic [15:0] p[7], logic [15:0] r);
    longint y;
    y = longint'($signed(p[0])) + longint'($signed(r));
    y = $signed(sat((y * longint'($signed(p[1]))) >>> 14));
    if (p[6][0])
      y = $signed(sat(((y * longint'($signed(p[3]))) >>> 14)
                      + longint'($signed(p[2]))));
    if (p[6][1])
      y = $signed(sat(((y * longint'($signed(p[5]))) >>> 14)
                      + longint'($signed(p[4]))));
    case (p[6][3:2])
      2'b01: return (y == -32768) ? 16'hFFFF :
                    (y < 0) ? {1'b1, 15'(-y)} : 16'(y);
      2'b10: return 16'(y) ^ 16'h8000;
      default: return 16'(y);
    endcase
  endfunction : model

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0]  pa[7] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h21, 8'h22, 8'h20};
    logic [7:0]  ra[9] = '{8'h12, 8'h14, 8'h13, 8'h20, 8'h22, 8'h08, 8'h4B,
                           8'h75, 8'hA5};
    logic [15:0] rv[9] = '{16'h4000, 16'h4000, 16'h0000, 16'h0001,
                           16'h4000, TYPE_CODE, CHAN_CNT, 16'h0, 16'h0};
    logic [15:0] prm[7];
    logic [15:0] r, e;
    int          i;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(negedge ref_clk);
    `CHK(proc_data, 32'h0)
    `CHK(run_led, 2'b11)
    `CHK(image_bytes, 4'h4)
    `CHK(irq, 1'b0)
    @(posedge ref_clk);
    // Reset contents, read-only type area, unmapped addresses
    for (i = 0; i < 9; i++) rd(ra[i], rv[i]);
    wr(8'h08, 16'hFFFF);
    rd(8'h08, TYPE_CODE);
    // Plain store words: each channel page keeps its own copy
    wr(8'h05, 16'hA5C3);
    wr(8'h45, 16'h3C5A);
    rd(8'h05, 16'hA5C3);
    rd(8'h45, 16'h3C5A);
    // Every scaling enable against every format, fast filter
    for (int k = 0; k < 16; k++) begin
      for (i = 0; i < 6; i++) prm[i] = $random(seed);
      prm[6] = 16'h0010 | 16'(k);
      r = $random(seed);
      adc_sample[0] <= r;
      for (i = 0; i < 7; i++) wr(pa[i], prm[i]);
      rd(8'h20, prm[6]);
      idle(50);
      e = model(prm, r);
      rd(8'h00, r);
      rd(8'h01, e);
      idle(0);
      @(negedge ref_clk);
      `CHK(proc_data[0], e)
      @(posedge ref_clk);
    end
    // Second channel kept defaults: slow, factory unity, full scale
    rd(8'h60, 16'h0001);
    idle(0);
    @(negedge ref_clk);
    `CHK(proc_data[1], 16'h8000)
    @(posedge ref_clk);
    adc_sample[1] <= 16'h7FFF;
    // Coupler falls silent; watchdog must raise the masked irq
    wr(8'h81, 16'h000C);
    hold <= 1'b1;
    idle(1);
    for (i = 0; i < 300 && irq !== 1'b1; i++) @(posedge ref_clk);
    if (irq !== 1'b1) begin
      num_errors++;
      conclude();
    end
    @(negedge ref_clk);
    `CHK(run_led, 2'b00)
    @(posedge ref_clk);
    hold <= 1'b0;
    idle(220);
    `CHK(run_led, 2'b11)
    `CHK(proc_data[1], 16'h7FFF)
    notes.push_back({16'h000C, 16'h000C});
    reg_rd <= 1'b1; reg_addr <= ADDR_IRQ_STAT;
    @(posedge ref_clk);
    idle(3);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_MASK, 16'h0000);
    parm <= 1'b1;
    idle(2);
    `CHK(image_bytes, 4'h6)
    conclude();
  end
endmodule : analog_input_scaling_channel_tb
